// ===== rsq_sync.sv
/*
  Two-flop level synchroniser for inputs that come from outside hclk.
  Assumes the input changes slower than one hclk period per level.
*/
`timescale 1ns/1ps

module rsq_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  if (WIDTH < 1) begin : g_chk
    $error("rsq_sync: WIDTH must be at least 1");
  end

  // First stage feeds the second stage only
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ===== rsq_pulse_filter.sv
/*
  Pulse filter: the output follows the input only after the input has
  held a new level for STABLE_CYCLES consecutive clocks.
  Assumes a synchronised input on the same clock.
*/
`timescale 1ns/1ps

module rsq_pulse_filter #(
  parameter int STABLE_CYCLES = 80,
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level_in,
  output logic level_out
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic out_reg;
  logic out_next;

  if (STABLE_CYCLES < 1) begin : g_chk
    $error("rsq_pulse_filter: STABLE_CYCLES must be at least 1");
  end

  // A short pulse restarts nothing but its own count and is dropped
  always_comb begin
    cnt_next = '0;
    out_next = out_reg;
    if (level_in != out_reg) begin
      if (cnt_reg == CW'(STABLE_CYCLES - 1)) begin
        out_next = level_in;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      out_reg <= RESET_VALUE;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign level_out = out_reg;

endmodule

// ===== rsq_sequencer.sv
/*
  Reset and start-up sequencer: constants package and top module.
  Assumes a 40 MHz hclk, an AHB-Lite master with this as its only slave,
  and asynchronous supply, brown-out, pin and oscillator inputs.
*/

package rsq_pkg;
  localparam int CLK_MHZ = 40;
  localparam int RC_TICK_NS = 1000;
  localparam int RC_TICK_CYCLES = RC_TICK_NS * CLK_MHZ / 1000;
  localparam int POWER_UP_DELAY_TIMER_TIME_US = 72000;
  localparam int POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_TIMER_TIME_US * 1000 / RC_TICK_NS;
  localparam int BOR_TIME_US = 100;
  localparam int BOR_TICKS = (BOR_TIME_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
  localparam int OST_CYCLES = 1024;
  localparam int PIN_FILTER_NS = 2000;
  localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

  localparam int CTRL_OSC_LSB = 0;
  localparam int CTRL_POWER_UP_DELAY_TIMER_EN_BIT = 2;
  localparam int CTRL_BOR_EN_BIT = 3;
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_POWERDOWN_BIT = 1;
  localparam int STAT_POR_N_BIT = 2;
  localparam int STAT_BOR_N_BIT = 3;
  localparam int STAT_CAUSE_LSB = 4;
  localparam int STAT_BUSY_BIT = 7;

  localparam logic [1:0] OSC_LP = 2'h0;
  localparam logic [1:0] OSC_XT = 2'h1;
  localparam logic [1:0] OSC_HS = 2'h2;
  localparam logic [1:0] OSC_RC = 2'h3;

  typedef struct packed {
    logic bor_en;
    logic power_up_delay_timer_en;
    logic [1:0] osc_mode;
  } rsq_cfg_s;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic por_status_n;
    logic bor_status_n;
  } rsq_flags_s;

  localparam rsq_cfg_s CFG_RESET = '{bor_en: 1'b1, power_up_delay_timer_en: 1'b0, osc_mode: OSC_RC};
  localparam rsq_flags_s FLAGS_RESET = '{timeout_flag: 1'b1, powerdown_flag: 1'b1,
                                         por_status_n: 1'b1, bor_status_n: 1'b1};

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_POWER_ON,
    CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_WDT_RESET,
    CAUSE_WDT_WAKE,
    CAUSE_BROWN_OUT
  } rsq_cause_e;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_HOLD,
    ST_POWER_UP_DELAY_TIMER,
    ST_OST,
    ST_FINAL,
    ST_WDT_RST,
    ST_RUN
  } rsq_state_e;
endpackage

`timescale 1ns/1ps

module rsq_sequencer #(
  parameter int POWER_UP_DELAY_TIMER_TICKS = rsq_pkg::POWER_UP_DELAY_TIMER_TICKS,
  parameter int BOR_TICKS = rsq_pkg::BOR_TICKS,
  parameter int OST_CYCLES = rsq_pkg::OST_CYCLES,
  parameter int RC_TICK_CYCLES = rsq_pkg::RC_TICK_CYCLES,
  parameter int PIN_FILTER_CYCLES = rsq_pkg::PIN_FILTER_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_reset_pin_n,
  input wire logic supply_ok,
  input wire logic low_supply_detect,
  input wire logic oscillator_input_pin,
  input wire logic watchdog_timeout,
  input wire logic core_sleeping,
  output logic reg_reset_n,
  output logic core_hold,
  output rsq_pkg::rsq_flags_s status_flags,
  output rsq_pkg::rsq_cause_e reset_cause
);

  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_TICKS + 1);
  localparam int BW = $clog2(BOR_TICKS + 1);
  localparam int OW = $clog2(OST_CYCLES + 1);
  localparam int DW = $clog2(RC_TICK_CYCLES + 1);

  if (POWER_UP_DELAY_TIMER_TICKS < 1 || BOR_TICKS < 1 || OST_CYCLES < 1 || RC_TICK_CYCLES < 1) begin : g_chk
    $error("rsq_sequencer: all counts must be at least 1");
  end

  logic pin_s;
  logic pin_f;
  logic supply_s;
  logic low_s;
  logic osc_s;

  // Pin is synchronised first, then filtered on hclk
  rsq_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(external_reset_pin_n),
    .sync_out(pin_s)
  );

  rsq_pulse_filter #(.STABLE_CYCLES(PIN_FILTER_CYCLES), .RESET_VALUE(1'b1)) u_pin_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .level_in(pin_s),
    .level_out(pin_f)
  );

  rsq_sync #(.WIDTH(3), .RESET_VALUE(3'h0)) u_misc_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({supply_ok, low_supply_detect, oscillator_input_pin}),
    .sync_out({supply_s, low_s, osc_s})
  );

  function automatic logic is_crystal(input logic [1:0] mode);
    is_crystal = (mode != rsq_pkg::OSC_RC);
  endfunction

  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] off);
    addr_hit = (a[rsq_pkg::ADDR_W-1:0] == off);
  endfunction

  rsq_pkg::rsq_state_e state_reg, state_next;
  rsq_pkg::rsq_cause_e cause_reg, cause_next;
  rsq_pkg::rsq_cfg_s cfg_reg, cfg_next;
  rsq_pkg::rsq_flags_s flags_reg, flags_next;
  logic [PW-1:0] power_up_delay_timer_cnt_reg, power_up_delay_timer_cnt_next;
  logic [BW-1:0] bor_cnt_reg, bor_cnt_next;
  logic [OW-1:0] ost_cnt_reg, ost_cnt_next;
  logic [DW-1:0] div_reg, div_next;
  logic supply_prev_reg, supply_prev_next;
  logic osc_prev_reg, osc_prev_next;
  logic reg_reset_n_reg, reg_reset_n_next;
  logic core_hold_reg, core_hold_next;
  logic wr_pend_reg, wr_pend_next;
  logic [31:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;

  logic rc_tick;
  logic osc_edge;
  logic bor_low;
  logic bor_trip;
  logic power_up_delay_timer_on;
  logic sw_set_por;
  logic sw_set_bor;
  logic addr_phase;

  // Timebase of the power-up delay, kept apart from the main oscillator
  always_comb begin
    div_next = (div_reg == DW'(RC_TICK_CYCLES - 1)) ? '0 : div_reg + DW'(1);
    rc_tick = (div_reg == DW'(RC_TICK_CYCLES - 1));
    supply_prev_next = supply_s;
    osc_prev_next = osc_s;
    osc_edge = osc_s && !osc_prev_reg;
  end

  // Low supply must persist for the minimum duration before it trips
  always_comb begin
    bor_low = cfg_reg.bor_en && low_s;
    bor_cnt_next = '0;
    if (bor_low) begin
      bor_cnt_next = bor_cnt_reg;
      if (rc_tick && bor_cnt_reg != BW'(BOR_TICKS)) begin
        bor_cnt_next = bor_cnt_reg + BW'(1);
      end
    end
    bor_trip = bor_low && (bor_cnt_reg == BW'(BOR_TICKS));
  end

  always_comb begin
    addr_phase = hsel && hready && htrans[1];
    wr_pend_next = addr_phase && hwrite;
    wr_addr_next = addr_phase ? haddr : wr_addr_reg;
    hrdata_next = hrdata_reg;
    if (addr_phase && !hwrite) begin
      hrdata_next = '0;
      if (addr_hit(haddr, rsq_pkg::CTRL_OFFSET)) begin
        hrdata_next[rsq_pkg::CTRL_OSC_LSB +: 2] = cfg_reg.osc_mode;
        hrdata_next[rsq_pkg::CTRL_POWER_UP_DELAY_TIMER_EN_BIT] = cfg_reg.power_up_delay_timer_en;
        hrdata_next[rsq_pkg::CTRL_BOR_EN_BIT] = cfg_reg.bor_en;
      end else if (addr_hit(haddr, rsq_pkg::STATUS_OFFSET)) begin
        hrdata_next[rsq_pkg::STAT_TIMEOUT_BIT] = flags_reg.timeout_flag;
        hrdata_next[rsq_pkg::STAT_POWERDOWN_BIT] = flags_reg.powerdown_flag;
        hrdata_next[rsq_pkg::STAT_POR_N_BIT] = flags_reg.por_status_n;
        hrdata_next[rsq_pkg::STAT_BOR_N_BIT] = flags_reg.bor_status_n;
        hrdata_next[rsq_pkg::STAT_CAUSE_LSB +: 3] = cause_reg;
        hrdata_next[rsq_pkg::STAT_BUSY_BIT] = core_hold_reg;
      end
    end
    cfg_next = cfg_reg;
    if (wr_pend_reg && addr_hit(wr_addr_reg, rsq_pkg::CTRL_OFFSET)) begin
      cfg_next.osc_mode = hwdata[rsq_pkg::CTRL_OSC_LSB +: 2];
      cfg_next.power_up_delay_timer_en = hwdata[rsq_pkg::CTRL_POWER_UP_DELAY_TIMER_EN_BIT];
      cfg_next.bor_en = hwdata[rsq_pkg::CTRL_BOR_EN_BIT];
    end
    sw_set_por = wr_pend_reg && addr_hit(wr_addr_reg, rsq_pkg::STATUS_OFFSET)
                 && hwdata[rsq_pkg::STAT_POR_N_BIT];
    sw_set_bor = wr_pend_reg && addr_hit(wr_addr_reg, rsq_pkg::STATUS_OFFSET)
                 && hwdata[rsq_pkg::STAT_BOR_N_BIT];
  end

  // Sequencer; supply loss and brown-out outrank the step in progress, pin and watchdog act only in ST_RUN
  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    flags_next = flags_reg;
    power_up_delay_timer_cnt_next = power_up_delay_timer_cnt_reg;
    ost_cnt_next = ost_cnt_reg;
    power_up_delay_timer_on = cfg_reg.power_up_delay_timer_en || cfg_reg.bor_en;
    // Software sets the POR and BOR status bits; a hardware clear in the same cycle wins
    if (sw_set_por) begin
      flags_next.por_status_n = 1'b1;
    end
    if (sw_set_bor) begin
      flags_next.bor_status_n = 1'b1;
    end
    if (!supply_s) begin
      state_next = rsq_pkg::ST_OFF;
    end else if (state_reg == rsq_pkg::ST_OFF) begin
      if (!supply_prev_reg) begin
        cause_next = rsq_pkg::CAUSE_POWER_ON;
        flags_next.timeout_flag = 1'b1;
        flags_next.powerdown_flag = 1'b1;
        flags_next.por_status_n = 1'b0;
        power_up_delay_timer_cnt_next = '0;
        ost_cnt_next = '0;
        if (power_up_delay_timer_on) begin
          state_next = rsq_pkg::ST_POWER_UP_DELAY_TIMER;
        end else if (is_crystal(cfg_reg.osc_mode)) begin
          state_next = rsq_pkg::ST_OST;
        end else begin
          state_next = rsq_pkg::ST_FINAL;
        end
      end
    end else if (bor_trip || (state_reg == rsq_pkg::ST_POWER_UP_DELAY_TIMER && bor_low
                 && cause_reg == rsq_pkg::CAUSE_BROWN_OUT)) begin
      state_next = rsq_pkg::ST_HOLD;
      cause_next = rsq_pkg::CAUSE_BROWN_OUT;
      flags_next.timeout_flag = 1'b1;
      flags_next.powerdown_flag = 1'b1;
      flags_next.bor_status_n = 1'b0;
    end else if (state_reg == rsq_pkg::ST_RUN && !pin_f) begin
      state_next = rsq_pkg::ST_HOLD;
      if (core_sleeping) begin
        cause_next = rsq_pkg::CAUSE_PIN_SLEEP;
        flags_next.timeout_flag = 1'b1;
        flags_next.powerdown_flag = 1'b0;
      end else begin
        cause_next = rsq_pkg::CAUSE_PIN_RUN;
      end
    end else if (state_reg == rsq_pkg::ST_RUN && watchdog_timeout) begin
      flags_next.timeout_flag = 1'b0;
      ost_cnt_next = '0;
      if (core_sleeping) begin
        cause_next = rsq_pkg::CAUSE_WDT_WAKE;
        flags_next.powerdown_flag = 1'b0;
        state_next = is_crystal(cfg_reg.osc_mode) ? rsq_pkg::ST_OST : rsq_pkg::ST_RUN;
      end else begin
        // Internal reset only; the pin is an input and is never driven
        cause_next = rsq_pkg::CAUSE_WDT_RESET;
        flags_next.powerdown_flag = 1'b1;
        state_next = rsq_pkg::ST_WDT_RST;
      end
    end else begin
      unique case (state_reg)
        rsq_pkg::ST_OFF: begin
          state_next = rsq_pkg::ST_OFF;
        end
        rsq_pkg::ST_HOLD: begin
          if (cause_reg == rsq_pkg::CAUSE_BROWN_OUT) begin
            if (!low_s || !cfg_reg.bor_en) begin
              power_up_delay_timer_cnt_next = '0;
              state_next = rsq_pkg::ST_POWER_UP_DELAY_TIMER;
            end
          end else if (pin_f) begin
            state_next = rsq_pkg::ST_RUN;
          end
        end
        rsq_pkg::ST_POWER_UP_DELAY_TIMER: begin
          // Pin level is not looked at here, so the delay runs on under a held pin
          if (rc_tick) begin
            power_up_delay_timer_cnt_next = power_up_delay_timer_cnt_reg + PW'(1);
            if (power_up_delay_timer_cnt_reg == PW'(POWER_UP_DELAY_TIMER_TICKS - 1)) begin
              ost_cnt_next = '0;
              state_next = is_crystal(cfg_reg.osc_mode) ? rsq_pkg::ST_OST
                                                        : rsq_pkg::ST_FINAL;
            end
          end
        end
        rsq_pkg::ST_OST: begin
          // Edges are seen through a synchroniser: the input must stay below hclk/2
          if (osc_edge) begin
            ost_cnt_next = ost_cnt_reg + OW'(1);
            if (ost_cnt_reg == OW'(OST_CYCLES - 1)) begin
              state_next = rsq_pkg::ST_FINAL;
            end
          end
        end
        rsq_pkg::ST_FINAL: begin
          if (pin_f) begin
            state_next = rsq_pkg::ST_RUN;
          end
        end
        rsq_pkg::ST_WDT_RST: begin
          state_next = rsq_pkg::ST_RUN;
        end
        rsq_pkg::ST_RUN: begin
          state_next = rsq_pkg::ST_RUN;
        end
        default: begin
          state_next = rsq_pkg::ST_OFF;
        end
      endcase
    end
    // Registered outputs release on an hclk edge only after every source is done
    core_hold_next = (state_next != rsq_pkg::ST_RUN);
    // A lost supply must reset registers even when the last cause was a wake
    reg_reset_n_next = !core_hold_next || (cause_next == rsq_pkg::CAUSE_WDT_WAKE
                       && state_next != rsq_pkg::ST_OFF);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= rsq_pkg::ST_OFF;
      cause_reg <= rsq_pkg::CAUSE_NONE;
      cfg_reg <= rsq_pkg::CFG_RESET;
      flags_reg <= rsq_pkg::FLAGS_RESET;
      power_up_delay_timer_cnt_reg <= '0;
      bor_cnt_reg <= '0;
      ost_cnt_reg <= '0;
      div_reg <= '0;
      supply_prev_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      reg_reset_n_reg <= 1'b0;
      core_hold_reg <= 1'b1;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      cfg_reg <= cfg_next;
      flags_reg <= flags_next;
      power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_next;
      bor_cnt_reg <= bor_cnt_next;
      ost_cnt_reg <= ost_cnt_next;
      div_reg <= div_next;
      supply_prev_reg <= supply_prev_next;
      osc_prev_reg <= osc_prev_next;
      reg_reset_n_reg <= reg_reset_n_next;
      core_hold_reg <= core_hold_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Zero-wait slave; hsize is not checked since only word transfers occur
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign reg_reset_n = reg_reset_n_reg;
  assign core_hold = core_hold_reg;
  assign status_flags = flags_reg;
  assign reset_cause = cause_reg;

endmodule

// ===== rsq_chk.sv
/*
  Port checker for rsq_sequencer.
  Assumes bind to the top; async inputs stay steady around each event.
*/
`timescale 1ns/1ps

module rsq_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic external_reset_pin_n,
  input wire logic supply_ok,
  input wire logic low_supply_detect,
  input wire logic watchdog_timeout,
  input wire logic core_sleeping,
  input wire logic reg_reset_n,
  input wire logic core_hold,
  input wire rsq_pkg::rsq_flags_s status_flags,
  input wire rsq_pkg::rsq_cause_e reset_cause
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic calm;
  // Only a settled running chip may take the watchdog
  assign calm = supply_ok && !low_supply_detect && external_reset_pin_n && !core_hold;

  chk_wdt_reset: assert property (calm && watchdog_timeout && !core_sleeping |=>
    core_hold && !reg_reset_n && reset_cause == rsq_pkg::CAUSE_WDT_RESET ##1 !core_hold)
    else $error("watchdog reset pulse wrong");
  chk_wdt_flags: assert property (calm && watchdog_timeout |=>
    !status_flags.timeout_flag && status_flags.powerdown_flag == !$past(core_sleeping))
    else $error("watchdog flags wrong");
  chk_wake_keeps: assert property (calm && watchdog_timeout && core_sleeping |=>
    reg_reset_n && reset_cause == rsq_pkg::CAUSE_WDT_WAKE)
    else $error("wake reset registers");
  chk_supply_off: assert property (!supply_ok [*4] |-> core_hold && !reg_reset_n)
    else $error("no hold without supply");
  chk_pin_hold: assert property (!external_reset_pin_n [*8] |-> core_hold)
    else $error("pin low but core runs");
  chk_bor_stay: assert property (reset_cause == rsq_pkg::CAUSE_BROWN_OUT && core_hold
    && low_supply_detect |=> core_hold)
    else $error("brown-out released early");
  chk_por_flags: assert property ($changed(reset_cause)
    && reset_cause == rsq_pkg::CAUSE_POWER_ON |-> status_flags[3:1] == 3'b110)
    else $error("power-on flags wrong");
  chk_bor_flags: assert property ($changed(reset_cause)
    && reset_cause == rsq_pkg::CAUSE_BROWN_OUT
    |-> {status_flags[3:2], status_flags[0]} == 3'b110)
    else $error("brown-out flags wrong");
  chk_release_clean: assert property ($fell(core_hold) |-> external_reset_pin_n && reg_reset_n)
    else $error("release while a source active");

  cover property (reset_cause == rsq_pkg::CAUSE_BROWN_OUT && core_hold);
  cover property (reset_cause == rsq_pkg::CAUSE_WDT_WAKE && core_hold);
  cover property (reset_cause == rsq_pkg::CAUSE_PIN_SLEEP && core_hold);
endmodule

bind rsq_sequencer rsq_chk rsq_chk_inst (.hclk(hclk), .hresetn(hresetn),
  .external_reset_pin_n(external_reset_pin_n), .supply_ok(supply_ok),
  .low_supply_detect(low_supply_detect), .watchdog_timeout(watchdog_timeout),
  .core_sleeping(core_sleeping), .reg_reset_n(reg_reset_n), .core_hold(core_hold),
  .status_flags(status_flags), .reset_cause(reset_cause));

// ===== rsq_far_side.sv
/*
  Far-side model: supply monitors, pulled-up reset pin network, crystal.
  Assumes the bench calls one task of a kind at a time.
*/
`timescale 1ns/1ps

module rsq_far_side #(
  parameter int OSC_HALF = 4
) (
  input wire logic hclk,
  output logic supply_ok,
  output logic low_supply_detect,
  output logic oscillator_input_pin,
  output wire logic external_reset_pin_n
);
  logic pin_req_n;
  int osc_cnt;
  initial begin
    supply_ok = 1'b0;
    low_supply_detect = 1'b0;
    oscillator_input_pin = 1'b0;
    pin_req_n = 1'b1;
    osc_cnt = 0;
  end
  // Crystal runs free at an eighth of hclk or slower, so every edge is countable
  always @(posedge hclk) begin
    osc_cnt <= (osc_cnt + 1) % OSC_HALF;
    if (osc_cnt == 0) begin
      oscillator_input_pin <= !oscillator_input_pin;
    end
  end
  // Board keeps the pin low while the supply is out of limits
  assign external_reset_pin_n = pin_req_n & supply_ok;
  task automatic set_supply(input logic v);
    @(posedge hclk);
    supply_ok <= v;
  endtask
  task automatic dip(input int n);
    @(posedge hclk);
    low_supply_detect <= 1'b1;
    repeat (n) @(posedge hclk);
    low_supply_detect <= 1'b0;
  endtask
  task automatic press(input int n);
    @(posedge hclk);
    pin_req_n <= 1'b0;
    repeat (n) @(posedge hclk);
    pin_req_n <= 1'b1;
  endtask
endmodule

// ===== tb.sv
/*
  Testbench for rsq_sequencer: bus, power-on, pin, watchdog, brown-out.
  Assumes shortened counts: 2-cycle tick, 20-tick delay, 8 crystal edges.
*/
`timescale 1ns/1ps

module tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic watchdog_timeout;
  logic core_sleeping;
  logic [31:0] hrdata, rd;
  logic hready, hresp, supply_ok, low_supply_detect, oscillator_input_pin;
  logic external_reset_pin_n, reg_reset_n, core_hold;
  rsq_pkg::rsq_flags_s status_flags;
  rsq_pkg::rsq_cause_e reset_cause;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;

  always #12.5 hclk = ~hclk;

  rsq_far_side rsq_far_side_inst (.hclk(hclk), .supply_ok(supply_ok),
    .low_supply_detect(low_supply_detect), .oscillator_input_pin(oscillator_input_pin),
    .external_reset_pin_n(external_reset_pin_n));

  rsq_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(20), .BOR_TICKS(3), .OST_CYCLES(8), .RC_TICK_CYCLES(2),
    .PIN_FILTER_CYCLES(4)) rsq_sequencer_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .external_reset_pin_n(external_reset_pin_n), .supply_ok(supply_ok),
    .low_supply_detect(low_supply_detect), .oscillator_input_pin(oscillator_input_pin),
    .watchdog_timeout(watchdog_timeout), .core_sleeping(core_sleeping),
    .reg_reset_n(reg_reset_n), .core_hold(core_hold), .status_flags(status_flags),
    .reset_cause(reset_cause));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wait_hold(input logic v);
    n = 0;
    while (core_hold !== v) begin
      @(negedge hclk);
      n++;
    end
  endtask
  task automatic power_on(input logic [3:0] cfg, input int lo, input int hi);
    rsq_far_side_inst.set_supply(1'b0);
    repeat (8) @(posedge hclk);
    bus(1'b1, 8'h00, {28'h0, cfg});
    rsq_far_side_inst.set_supply(1'b1);
    @(negedge hclk);
    wait_hold(1'b0);
    check(32'(n >= lo && n <= hi), 32'h1);
    check(status_flags[3:1], 3'b110);
    check(reset_cause, rsq_pkg::CAUSE_POWER_ON);
    check(reg_reset_n, 1'b1);
  endtask
  task automatic pin_reset(input logic sleep, input logic [3:0] flags);
    @(posedge hclk);
    core_sleeping <= sleep;
    fork
      rsq_far_side_inst.press(30);
    join_none
    wait_hold(1'b1);
    check(reset_cause, sleep ? rsq_pkg::CAUSE_PIN_SLEEP : rsq_pkg::CAUSE_PIN_RUN);
    check(status_flags, flags);
    wait_hold(1'b0);
    check(32'(n >= 20 && n <= 40), 32'h1);
    @(posedge hclk);
    core_sleeping <= 1'b0;
  endtask
  task automatic wdt(input logic sleep, input logic [3:0] seen, input int lo, input int hi);
    @(posedge hclk);
    core_sleeping <= sleep;
    watchdog_timeout <= 1'b1;
    @(posedge hclk);
    watchdog_timeout <= 1'b0;
    @(negedge hclk);
    check({core_hold, reg_reset_n, status_flags[3:2]}, seen);
    check(external_reset_pin_n, 1'b1);
    check(reset_cause, sleep ? rsq_pkg::CAUSE_WDT_WAKE : rsq_pkg::CAUSE_WDT_RESET);
    wait_hold(1'b0);
    check(32'(n >= lo && n <= hi), 32'h1);
    @(posedge hclk);
    core_sleeping <= 1'b0;
  endtask

  // A hang anywhere ends the run through the same report
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    watchdog_timeout = 1'b0;
    core_sleeping = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000000b);
    bus(1'b1, 8'h08, 32'hffffffff);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    power_on(4'hb, 40, 56);
    bus(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000001b);
    for (int m = 0; m < 3; m++) begin
      power_on({2'b00, 2'(m)}, 56, 80);
    end
    power_on(4'h3, 2, 16);
    power_on(4'h5, 96, 136);
    bus(1'b1, 8'h04, 32'h4);
    bus(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000001f);
    rsq_far_side_inst.press(2);
    n = 0;
    repeat (16) begin
      @(negedge hclk);
      if (core_hold !== 1'b0) n++;
    end
    check(n, 0);
    pin_reset(1'b0, 4'hf);
    pin_reset(1'b1, 4'hb);
    wdt(1'b0, 4'b1001, 1, 2);
    bus(1'b1, 8'h00, 32'h1);
    wdt(1'b1, 4'b1100, 50, 80);
    bus(1'b1, 8'h00, 32'h3);
    wdt(1'b1, 4'b0100, 0, 0);
    rsq_far_side_inst.dip(30);
    @(negedge hclk);
    check(core_hold, 1'b0);
    bus(1'b1, 8'h00, 32'hb);
    rsq_far_side_inst.dip(30);
    @(negedge hclk);
    check(reset_cause, rsq_pkg::CAUSE_BROWN_OUT);
    check(status_flags, 4'he);
    repeat (20) @(posedge hclk);
    check(core_hold, 1'b1);
    rsq_far_side_inst.dip(4);
    @(negedge hclk);
    wait_hold(1'b0);
    check(32'(n >= 40 && n <= 56), 32'h1);
    end_sim();
  end
endmodule
